// >>> core/fsd_pkg.sv
// Constants, types and helpers for the flash security status decoder
//
// Notes on behaviour
// - Read-only byte at index 2h; writes ignored.
// - Byte loaded from security byte during reset.
// - Backdoor key access only for pattern 10.
// - Mass erase disabled only for pattern 10.
// - Mass erase field ignored while unsecure.
// - Factory access granted for 00 and 11.
// - Secure plus denied blocks factory flash reads.
// - Factory field ignored while unsecure.
// - Security pattern 10 unsecure, others secure.
// - Backdoor unlock forces security field to 10.
// - Secure state restricts flash resource access.
package fsd_pkg;

    localparam int FSD_AW = 12;

    // Register indices; byte address is four times the index
    localparam int FSD_SEC_IDX = 2;
    localparam int FSD_CTRL_IDX = 3;
    localparam int FSD_STAT_IDX = 4;
    localparam logic [FSD_AW-1:0] FSD_SEC_ADDR = FSD_AW'(FSD_SEC_IDX * 4);
    localparam logic [FSD_AW-1:0] FSD_CTRL_ADDR = FSD_AW'(FSD_CTRL_IDX * 4);
    localparam logic [FSD_AW-1:0] FSD_STAT_ADDR = FSD_AW'(FSD_STAT_IDX * 4);

    // Field low bit positions inside the security byte
    localparam int FSD_KEY_LSB = 6;
    localparam int FSD_ME_LSB = 4;
    localparam int FSD_FA_LSB = 2;
    localparam int FSD_SEC_LSB = 0;

    localparam logic [1:0] FSD_KEY_ON = 2'h2;
    localparam logic [1:0] FSD_ME_OFF = 2'h2;
    localparam logic [1:0] FSD_FA_DENY_A = 2'h1;
    localparam logic [1:0] FSD_FA_DENY_B = 2'h2;
    localparam logic [1:0] FSD_SEC_UNSEC = 2'h2;

    // Value held before the first load: secure, everything denied
    localparam logic [7:0] FSD_SEC_RST = 8'h00;

    localparam int FSD_CTRL_RELOAD = 0;
    localparam int FSD_ST_DONE = 0;
    localparam int FSD_ST_SECURE = 1;
    localparam int FSD_ST_KEY = 2;
    localparam int FSD_ST_ME = 3;
    localparam int FSD_ST_FA = 4;

    typedef enum logic [1:0] {
        FSD_LD_IDLE = 2'b00,
        FSD_LD_REQ = 2'b01,
        FSD_LD_READY = 2'b10
    } fsd_load_t;

    typedef struct packed {
        logic backdoor_en;
        logic mass_erase_en;
        logic factory_read_en;
        logic secure;
        logic restrict_access;
    } fsd_qual_t;

    function automatic logic [1:0] fsd_field(input logic [7:0] b, input int lsb);
        fsd_field = b[lsb+:2];
    endfunction

endpackage

// >>> core/fsd_field_decode.sv
// Combinational decode of the security byte into access qualifiers
module fsd_field_decode
    import fsd_pkg::*;
(
    input wire logic [7:0] sec_byte_i,
    input wire logic valid_i,
    input wire logic normal_mode_i,
    output fsd_qual_t qual_o
);

    logic secure;
    logic fa_granted;
    logic me_field_off;

    always_comb begin
        // Until loaded, the byte is untrusted: treat the part as secure
        secure = !valid_i || (fsd_field(sec_byte_i, FSD_SEC_LSB) != FSD_SEC_UNSEC);
        fa_granted = (fsd_field(sec_byte_i, FSD_FA_LSB) != FSD_FA_DENY_A)
            && (fsd_field(sec_byte_i, FSD_FA_LSB) != FSD_FA_DENY_B);
        me_field_off = fsd_field(sec_byte_i, FSD_ME_LSB) == FSD_ME_OFF;
        qual_o.secure = secure;
        qual_o.backdoor_en = valid_i && (fsd_field(sec_byte_i, FSD_KEY_LSB) == FSD_KEY_ON);
        // Field only counts while secure outside normal mode
        qual_o.mass_erase_en = valid_i && !(secure && !normal_mode_i && me_field_off);
        // Unsecure overrides the factory field
        qual_o.factory_read_en = valid_i && (!secure || fa_granted);
        qual_o.restrict_access = secure;
    end

endmodule

// >>> core/fsd_security_status.sv
// Flash security status register with APB access and reset-time load
module fsd_security_status
    import fsd_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [FSD_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic NVM_REQ_O,
    input wire logic NVM_VALID_I,
    input wire logic [7:0] NVM_BYTE_I,
    input wire logic BACKDOOR_UNLOCK_I,
    input wire logic ERASE_ALL_DONE_I,
    input wire logic NORMAL_MODE_I,
    output logic SEC_VALID_O,
    output fsd_qual_t QUAL_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Load sequencer and security byte

    fsd_load_t state_reg;
    fsd_load_t state_next;
    logic [7:0] sec_reg;
    logic [7:0] sec_next;
    logic reload_req;
    logic valid;

    assign valid = (state_reg == FSD_LD_READY);

    always_comb begin
        state_next = state_reg;
        sec_next = sec_reg;
        case (state_reg)
            FSD_LD_IDLE: begin
                state_next = FSD_LD_REQ;
            end
            FSD_LD_REQ: begin
                if (NVM_VALID_I) begin
                    sec_next = NVM_BYTE_I;
                    state_next = FSD_LD_READY;
                end
            end
            FSD_LD_READY: begin
                // Reload takes the byte fresh; a pending unlock is dropped
                if (reload_req) begin
                    state_next = FSD_LD_REQ;
                end else if (BACKDOOR_UNLOCK_I || ERASE_ALL_DONE_I) begin
                    sec_next[FSD_SEC_LSB+:2] = FSD_SEC_UNSEC;
                end
            end
            default: begin
                state_next = FSD_LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state_reg <= FSD_LD_IDLE;
            sec_reg <= FSD_SEC_RST;
        end else begin
            state_reg <= state_next;
            sec_reg <= sec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    fsd_qual_t qual;

    fsd_field_decode u_decode (
        .sec_byte_i(sec_reg),
        .valid_i(valid),
        .normal_mode_i(NORMAL_MODE_I),
        .qual_o(qual)
    );

    assign QUAL_O = qual;
    assign SEC_VALID_O = valid;
    assign NVM_REQ_O = (state_reg == FSD_LD_REQ);

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state so read data comes from a flop

    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic access_first;
    logic done;
    logic mapped;
    logic [7:0] stat_byte;

    assign access_first = PSEL_I && PENABLE_I && !pready_reg;
    assign done = PSEL_I && PENABLE_I && pready_reg;
    assign mapped = (PADDR_I == FSD_SEC_ADDR) || (PADDR_I == FSD_CTRL_ADDR)
        || (PADDR_I == FSD_STAT_ADDR);
    // Low lane carries the control byte; upper lanes are ignored
    assign reload_req = done && PWRITE_I && (PADDR_I == FSD_CTRL_ADDR)
        && PSTRB_I[0] && PWDATA_I[FSD_CTRL_RELOAD];

    always_comb begin
        stat_byte = 8'h00;
        stat_byte[FSD_ST_DONE] = valid;
        stat_byte[FSD_ST_SECURE] = qual.secure;
        stat_byte[FSD_ST_KEY] = qual.backdoor_en;
        stat_byte[FSD_ST_ME] = qual.mass_erase_en;
        stat_byte[FSD_ST_FA] = qual.factory_read_en;
    end

    always_comb begin
        pready_next = access_first;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (access_first) begin
            pslverr_next = !mapped;
            prdata_next = 32'h0000_0000;
            if (!PWRITE_I) begin
                case (PADDR_I)
                    FSD_SEC_ADDR: begin
                        prdata_next = {24'h00_0000, sec_reg};
                    end
                    FSD_STAT_ADDR: begin
                        prdata_next = {24'h00_0000, stat_byte};
                    end
                    default: begin
                        prdata_next = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign PRDATA_O = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_write_ignored: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (done && PWRITE_I && PADDR_I == FSD_SEC_ADDR && valid
            && !BACKDOOR_UNLOCK_I && !ERASE_ALL_DONE_I)
        |=> (sec_reg == $past(sec_reg)) && valid)
        else $error("write changed the security byte");

    a_read_sec_data: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (access_first && !PWRITE_I && PADDR_I == FSD_SEC_ADDR)
        |=> PREADY_O && !PSLVERR_O && PRDATA_O == {24'h00_0000, $past(sec_reg)})
        else $error("security byte read returned wrong data");

    a_write_no_data: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (access_first && PWRITE_I) |=> PRDATA_O == 32'h0000_0000)
        else $error("write returned read data");

    a_mapped_no_err: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (access_first && mapped) |=> PREADY_O && !PSLVERR_O)
        else $error("mapped access flagged as error");

    ////////////////////////////////////////////////////////////////////////////
    // Assertions on reset, load and unlock

    // Left without disable so that it can watch reset itself
    a_reset_state: assert property (@(posedge CLOCK_I)
        RESET_I |=> !SEC_VALID_O && !NVM_REQ_O && !PREADY_O && !PSLVERR_O
            && PRDATA_O == 32'h0000_0000 && QUAL_O.secure)
        else $error("outputs not at reset values");

    a_req_after_reset: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        $fell(RESET_I) |=> NVM_REQ_O && !SEC_VALID_O)
        else $error("no NVM request after reset");

    a_req_until_valid: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (NVM_REQ_O && !NVM_VALID_I) |=> NVM_REQ_O && !SEC_VALID_O)
        else $error("NVM request dropped without a byte");

    a_load_capture: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (state_reg == FSD_LD_REQ && NVM_VALID_I)
        |=> SEC_VALID_O && !NVM_REQ_O && sec_reg == $past(NVM_BYTE_I))
        else $error("security byte not captured from NVM");

    // A reload must win over an unlock in the same cycle
    a_reload_wins: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (reload_req && valid)
        |=> !SEC_VALID_O && NVM_REQ_O && sec_reg == $past(sec_reg))
        else $error("reload did not restart the load");

    a_hold_loaded: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (valid && !BACKDOOR_UNLOCK_I && !ERASE_ALL_DONE_I)
        |=> sec_reg == $past(sec_reg))
        else $error("security byte moved without cause");

    a_unlock_forces: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (valid && BACKDOOR_UNLOCK_I && !reload_req)
        |=> sec_reg[FSD_SEC_LSB+:2] == FSD_SEC_UNSEC && !QUAL_O.secure
            && sec_reg[7:2] == $past(sec_reg[7:2]))
        else $error("unlock did not report unsecure");

    a_erase_forces: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (valid && ERASE_ALL_DONE_I && !reload_req)
        |=> sec_reg[FSD_SEC_LSB+:2] == FSD_SEC_UNSEC && QUAL_O.factory_read_en
            && sec_reg[7:2] == $past(sec_reg[7:2]))
        else $error("erase-all did not report unsecure");

    ////////////////////////////////////////////////////////////////////////////
    // Assertions on the field decode

    a_key_decode: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        valid |-> QUAL_O.backdoor_en == (sec_reg[7:6] == 2'h2))
        else $error("backdoor enable decode wrong");

    a_secure_decode: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        QUAL_O.secure == (!SEC_VALID_O || sec_reg[1:0] != 2'h2))
        else $error("secure decode wrong");

    a_restrict_secure: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        QUAL_O.restrict_access == QUAL_O.secure)
        else $error("restriction differs from secure state");

    a_mass_erase: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        valid |-> QUAL_O.mass_erase_en
            == (sec_reg[1:0] == 2'h2 || NORMAL_MODE_I || sec_reg[5:4] != 2'h2))
        else $error("mass erase decode wrong");

    a_me_unsecure: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (valid && sec_reg[1:0] == 2'h2) |-> QUAL_O.mass_erase_en)
        else $error("mass erase field applied while unsecure");

    a_factory_gate: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        valid |-> QUAL_O.factory_read_en
            == (sec_reg[1:0] == 2'h2 || sec_reg[3:2] == 2'h0 || sec_reg[3:2] == 2'h3))
        else $error("factory access decode wrong");

    a_fa_unsecure: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (valid && sec_reg[1:0] == 2'h2)
        |-> QUAL_O.factory_read_en && !QUAL_O.restrict_access)
        else $error("factory field applied while unsecure");

    a_quiet_unloaded: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        !SEC_VALID_O |-> !QUAL_O.backdoor_en && !QUAL_O.factory_read_en
            && QUAL_O.restrict_access)
        else $error("qualifiers active before load");

    // Mode input is compared over the same edge as the qualifiers it feeds
    a_stable_qual: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (valid && !BACKDOOR_UNLOCK_I && !ERASE_ALL_DONE_I && !reload_req)
            ##1 $stable(NORMAL_MODE_I)
        |-> $stable(QUAL_O))
        else $error("qualifiers moved without cause");

    a_status_read: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (access_first && !PWRITE_I && PADDR_I == FSD_STAT_ADDR)
        |=> PRDATA_O == {27'h0, $past(QUAL_O.factory_read_en), $past(QUAL_O.mass_erase_en),
            $past(QUAL_O.backdoor_en), $past(QUAL_O.secure), $past(SEC_VALID_O)})
        else $error("status read returned wrong data");

    ////////////////////////////////////////////////////////////////////////////
    // Assertions on the bus handshake

    a_one_wait: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        access_first |=> PREADY_O ##1 !PREADY_O)
        else $error("APB answer not after one wait state");

    a_ready_pulse: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");

    a_err_with_ready: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        PSLVERR_O |-> PREADY_O)
        else $error("error shown without ready");

    a_ctrl_reads_zero: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (access_first && !PWRITE_I && PADDR_I == FSD_CTRL_ADDR)
        |=> PRDATA_O == 32'h0000_0000)
        else $error("control register read not zero");

    a_unmapped_err: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (access_first && !mapped) |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
        else $error("unmapped access not flagged");

endmodule

// >>> dv/flash_security_status_decode_tb_top.sv
// Self-checking bench for the flash security status register
module flash_security_status_decode_tb_top
    import fsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [FSD_AW-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic nvm_valid = 1'b0;
    logic [7:0] nvm_byte = 8'h00;
    logic unlock = 1'b0;
    logic erase = 1'b0;
    logic normal = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic nvm_req;
    logic sec_valid;
    fsd_qual_t qual;
    int err_count = 0;
    int cmp_count = 0;
    // Every pattern of every field appears at least once
    logic [7:0] tbl [6] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'hA9, 8'h54};

    fsd_security_status dut (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .NVM_REQ_O(nvm_req), .NVM_VALID_I(nvm_valid),
        .NVM_BYTE_I(nvm_byte), .BACKDOOR_UNLOCK_I(unlock), .ERASE_ALL_DONE_I(erase),
        .NORMAL_MODE_I(normal), .SEC_VALID_O(sec_valid), .QUAL_O(qual));

    initial begin
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Starts one edge later so psel is never reassigned in the releasing time step
    task automatic apb(input logic w, input logic [FSD_AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'(pready), 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic load(input logic [7:0] b);
        int n;
        n = 0;
        apb(1'b1, FSD_CTRL_ADDR, 32'h1);
        @(posedge clk);
        chk("valid drop", 32'(sec_valid), 32'h0);
        while (nvm_req !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("nvm request", 32'(nvm_req), 32'h1);
        nvm_valid <= 1'b1;
        nvm_byte <= b;
        @(posedge clk);
        nvm_valid <= 1'b0;
        nvm_byte <= ~b;
        @(posedge clk);
        chk("loaded", 32'(sec_valid), 32'h1);
    endtask

    function automatic fsd_qual_t exp_q(input logic [7:0] b, input logic nm);
        fsd_qual_t q;
        logic s;
        s = (b[1:0] != 2'b10);
        q.secure = s;
        q.restrict_access = s;
        q.backdoor_en = (b[7:6] == 2'b10);
        q.mass_erase_en = !(s && !nm && b[5:4] == 2'b10);
        q.factory_read_en = !s || b[3:2] == 2'b00 || b[3:2] == 2'b11;
        return q;
    endfunction

    task automatic check_byte(input logic [7:0] b, input logic nm);
        fsd_qual_t q;
        q = exp_q(b, nm);
        chk("qual", 32'(qual), 32'(q));
        apb(1'b0, FSD_SEC_ADDR, 32'h0);
        chk("sec byte", rd, {24'h0, b});
        apb(1'b0, FSD_STAT_ADDR, 32'h0);
        chk("status", rd, {27'h0, q.factory_read_en, q.mass_erase_en, q.backdoor_en, q.secure, 1'b1});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, FSD_SEC_ADDR, 32'h0);
        chk("pre-load byte", rd, 32'h0);
        chk("pre-load secure", 32'(qual.secure), 32'h1);
        foreach (tbl[i]) begin
            for (int m = 0; m < 2; m++) begin
                normal <= m[0];
                load(tbl[i]);
                check_byte(tbl[i], m[0]);
            end
        end
        apb(1'b1, FSD_SEC_ADDR, 32'hFF);
        chk("write err", 32'(er), 32'h0);
        apb(1'b0, FSD_CTRL_ADDR, 32'h0);
        chk("ctrl read", rd, 32'h0);
        check_byte(tbl[5], 1'b1);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        chk("unmapped data", rd, 32'h0);
        load(8'hA9);
        unlock <= 1'b1;
        @(posedge clk);
        unlock <= 1'b0;
        @(posedge clk);
        check_byte(8'hAA, 1'b1);
        load(8'h54);
        erase <= 1'b1;
        @(posedge clk);
        erase <= 1'b0;
        @(posedge clk);
        check_byte(8'h56, 1'b1);
        stop_test;
    end

    // Whole run needs a few hundred cycles; this cuts a stuck handshake short
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        stop_test;
    end
endmodule
